// File: rtl/sbh_pkg.sv
// Constants for the subtract, special-page and halt execution block
package sbh_pkg;

  // Instruction codes on the issue port
  localparam logic [1:0] OP_SUB_BORROW_IMM = 2'h0;
  localparam logic [1:0] OP_PAGE_READ      = 2'h1;
  localparam logic [1:0] OP_PAGE_WRITE     = 2'h2;
  localparam logic [1:0] OP_HALT           = 2'h3;

  // Register offsets on the software port
  localparam logic [3:0] OFS_STATUS   = 4'h0;
  localparam logic [3:0] OFS_WORK     = 4'h1;
  localparam logic [3:0] OFS_WDOG     = 4'h2;
  localparam logic [3:0] OFS_PRESCALE = 4'h3;
  localparam logic [3:0] OFS_WAKE     = 4'h4;

  // Status register field positions, and the wake bit of the wake register
  localparam int BIT_CARRY   = 0;
  localparam int BIT_NIBBLE  = 1;
  localparam int BIT_ZERO    = 2;
  localparam int BIT_PDOWN_N = 3;
  localparam int BIT_TOUT_N  = 4;
  localparam int BIT_HALTED  = 5;
  localparam int BIT_WAKE    = 0;

  // Values after reset, and the page depth
  localparam logic [7:0] RST_WORK     = 8'h00;
  localparam logic [7:0] RST_WDOG     = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic       RST_TOUT_N   = 1'b1;
  localparam logic       RST_PDOWN_N  = 1'b1;
  localparam logic [7:0] PAGE_RST     = 8'h00;
  localparam int         PAGE_DEPTH   = 16;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FILL,
    ST_HALT
  } sbh_state_e;

endpackage

// File: rtl/sbh_page_mem.sv
// Sixteen-entry special-function page with registered read data
module sbh_page_mem (
  input  wire logic       clk_in,     // Core clock
  input  wire logic       rst_n_in,   // Async reset, active low
  input  wire logic       wr_in,      // Write enable
  input  wire logic [3:0] wr_idx_in,  // Write index
  input  wire logic [7:0] wr_data_in, // Write data
  input  wire logic [3:0] rd_idx_in,  // Read index
  output logic      [7:0] rd_data_out // Read data, registered
);

  logic [7:0] page_reg [sbh_pkg::PAGE_DEPTH];
  logic [7:0] rd_data_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < sbh_pkg::PAGE_DEPTH; i++) begin
        page_reg[i] <= sbh_pkg::PAGE_RST;
      end
    end else if (wr_in) begin
      page_reg[wr_idx_in] <= wr_data_in;
    end
  end

  // Read sees the array before a same-edge write lands
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_reg <= sbh_pkg::PAGE_RST;
    end else begin
      rd_data_reg <= page_reg[rd_idx_in];
    end
  end

  assign rd_data_out = rd_data_reg;

endmodule

// File: rtl/sbh_sub_alu.sv
// Combinational subtract-with-borrow datapath and its flags
module sbh_sub_alu (
  input  wire logic [7:0] imm_in,    // Immediate operand
  input  wire logic [7:0] work_in,   // Working register
  input  wire logic       carry_in,  // Carry, inverted borrow
  output logic      [7:0] result_out, // Difference
  output logic            carry_out,  // Carry out of bit 7
  output logic            nibble_out, // Carry out of bit 3
  output logic            zero_out    // Result is zero
);

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  logic [8:0] sum_full;
  logic [4:0] sum_low;

  assign sum_full   = {1'b0, imm_in} + {1'b0, ~work_in} + {8'h00, carry_in};
  assign sum_low    = {1'b0, imm_in[3:0]} + {1'b0, ~work_in[3:0]} + {4'h0, carry_in};
  assign result_out = sum_full[7:0];
  assign carry_out  = sum_full[8];
  assign nibble_out = sum_low[4];
  assign zero_out   = is_zero(sum_full[7:0]);

endmodule

// File: rtl/sbh_exec.sv
// Execution unit for subtract-with-borrow, special-page moves and halt
module sbh_exec (
  input  wire logic       CLK_IN,                // Core instruction clock, 10 MHz
  input  wire logic       RST_N_IN,              // Async reset, active low
  input  wire logic       OP_VALID_IN,           // Instruction offered
  input  wire logic [1:0] OP_CODE_IN,            // Instruction code
  input  wire logic [7:0] OP_ARG_IN,             // Immediate or page index
  output logic            OP_READY_OUT,          // Unit accepts an instruction
  output logic            OP_DONE_OUT,           // Pulse: an instruction completed
  input  wire logic [3:0] BUS_ADDR_IN,           // Register address
  input  wire logic [7:0] BUS_WDATA_IN,          // Register write data
  input  wire logic       BUS_WR_IN,             // Write strobe
  input  wire logic       BUS_RD_IN,             // Read strobe
  output logic      [7:0] BUS_RDATA_OUT,         // Read data, cycle after strobe
  output logic      [7:0] WORK_REG_OUT,          // Working register
  output logic            CARRY_OUT,             // Carry flag
  output logic            NIBBLE_CARRY_OUT,      // Nibble carry flag
  output logic            ZERO_OUT,              // Zero flag
  output logic            TIMEOUT_FLAG_N_OUT,    // Time-out flag, active low
  output logic            POWER_DOWN_FLAG_N_OUT, // Power-down flag, active low
  output logic            HALTED_OUT,            // Halt mode
  output logic      [7:0] WDOG_COUNT_OUT,        // Watchdog count
  output logic      [7:0] WDOG_PRESCALER_OUT     // Watchdog prescaler
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  sbh_pkg::sbh_state_e state_reg;
  sbh_pkg::sbh_state_e state_next;
  logic [7:0] work_reg;
  logic [7:0] work_next;
  logic       carry_reg;
  logic       carry_next;
  logic       nibble_reg;
  logic       nibble_next;
  logic       zero_reg;
  logic       zero_next;
  logic       tout_n_reg;
  logic       tout_n_next;
  logic       pdown_n_reg;
  logic       pdown_n_next;
  logic [7:0] wdog_reg;
  logic [7:0] wdog_next;
  logic [7:0] presc_reg;
  logic [7:0] presc_next;
  logic       ready_reg;
  logic       halted_reg;
  logic       done_reg;
  logic       done_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire op_take     = OP_VALID_IN && ready_reg;
  wire take_sub    = op_take && (OP_CODE_IN == sbh_pkg::OP_SUB_BORROW_IMM);
  wire take_pread  = op_take && (OP_CODE_IN == sbh_pkg::OP_PAGE_READ);
  wire take_pwrite = op_take && (OP_CODE_IN == sbh_pkg::OP_PAGE_WRITE);
  wire take_halt   = op_take && (OP_CODE_IN == sbh_pkg::OP_HALT);
  wire in_fill     = (state_reg == sbh_pkg::ST_FILL);
  wire in_halt     = (state_reg == sbh_pkg::ST_HALT);

  wire wr_status = BUS_WR_IN && (BUS_ADDR_IN == sbh_pkg::OFS_STATUS);
  wire wr_work   = BUS_WR_IN && (BUS_ADDR_IN == sbh_pkg::OFS_WORK);
  wire wr_wake   = BUS_WR_IN && (BUS_ADDR_IN == sbh_pkg::OFS_WAKE) && BUS_WDATA_IN[sbh_pkg::BIT_WAKE];

  ////////////////////////////////////////////////////////////////////////////
  // Datapath helpers
  logic [7:0] alu_result;
  logic       alu_carry;
  logic       alu_nibble;
  logic       alu_zero;
  logic [7:0] page_rdata;

  sbh_sub_alu u_alu (
    .imm_in     (OP_ARG_IN),
    .work_in    (work_reg),
    .carry_in   (carry_reg),
    .result_out (alu_result),
    .carry_out  (alu_carry),
    .nibble_out (alu_nibble),
    .zero_out   (alu_zero)
  );

  // Index is the low four bits; the page is read every cycle so the data is ready next edge
  sbh_page_mem u_page (
    .clk_in      (CLK_IN),
    .rst_n_in    (RST_N_IN),
    .wr_in       (take_pwrite),
    .wr_idx_in   (OP_ARG_IN[3:0]),
    .wr_data_in  (work_reg),
    .rd_idx_in   (OP_ARG_IN[3:0]),
    .rd_data_out (page_rdata)
  );

  wire [7:0] status_view = {2'b00, in_halt, tout_n_reg, pdown_n_reg, zero_reg, nibble_reg, carry_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sbh_pkg::ST_RUN: begin
        if (take_halt) begin
          state_next = sbh_pkg::ST_HALT;
        end else if (take_pread) begin
          state_next = sbh_pkg::ST_FILL;
        end
      end
      sbh_pkg::ST_FILL: begin
        state_next = sbh_pkg::ST_RUN;
      end
      sbh_pkg::ST_HALT: begin
        if (wr_wake) begin
          state_next = sbh_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Instruction results override a same-cycle software write
  always_comb begin
    work_next = work_reg;
    if (take_sub) begin
      work_next = alu_result;
    end else if (in_fill) begin
      work_next = page_rdata;
    end else if (wr_work) begin
      work_next = BUS_WDATA_IN;
    end
  end

  always_comb begin
    carry_next  = carry_reg;
    nibble_next = nibble_reg;
    zero_next   = zero_reg;
    if (take_sub) begin
      carry_next  = alu_carry;
      nibble_next = alu_nibble;
      zero_next   = alu_zero;
    end else if (wr_status) begin
      carry_next  = BUS_WDATA_IN[sbh_pkg::BIT_CARRY];
      nibble_next = BUS_WDATA_IN[sbh_pkg::BIT_NIBBLE];
      zero_next   = BUS_WDATA_IN[sbh_pkg::BIT_ZERO];
    end
  end

  // Halt wins over a software write of the same cycle
  always_comb begin
    tout_n_next  = tout_n_reg;
    pdown_n_next = pdown_n_reg;
    if (take_halt) begin
      tout_n_next  = 1'b1;
      pdown_n_next = 1'b0;
    end else if (wr_status) begin
      tout_n_next  = BUS_WDATA_IN[sbh_pkg::BIT_TOUT_N];
      pdown_n_next = BUS_WDATA_IN[sbh_pkg::BIT_PDOWN_N];
    end
  end

  // Minimal watchdog time base: counts only while running, frozen in halt mode
  always_comb begin
    presc_next = presc_reg;
    wdog_next  = wdog_reg;
    if (take_halt) begin
      presc_next = 8'h00;
      wdog_next  = 8'h00;
    end else if (!in_halt) begin
      presc_next = presc_reg + 8'h01;
      if (presc_reg == 8'hFF) begin
        wdog_next = wdog_reg + 8'h01;
      end
    end
  end

  assign done_next = take_sub || take_pwrite || take_halt || in_fill;

  always_comb begin
    rdata_next = 8'h00;
    if (BUS_RD_IN) begin
      unique case (BUS_ADDR_IN)
        sbh_pkg::OFS_STATUS:   rdata_next = status_view;
        sbh_pkg::OFS_WORK:     rdata_next = work_reg;
        sbh_pkg::OFS_WDOG:     rdata_next = wdog_reg;
        sbh_pkg::OFS_PRESCALE: rdata_next = presc_reg;
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= sbh_pkg::ST_RUN;
      ready_reg <= 1'b1;
      halted_reg <= 1'b0;
      done_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == sbh_pkg::ST_RUN);
      // Own flop so the halt pin does not hang off the state decoder
      halted_reg <= (state_next == sbh_pkg::ST_HALT);
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      work_reg    <= sbh_pkg::RST_WORK;
      carry_reg   <= 1'b0;
      nibble_reg  <= 1'b0;
      zero_reg    <= 1'b0;
      tout_n_reg  <= sbh_pkg::RST_TOUT_N;
      pdown_n_reg <= sbh_pkg::RST_PDOWN_N;
      wdog_reg    <= sbh_pkg::RST_WDOG;
      presc_reg   <= sbh_pkg::RST_PRESCALE;
    end else begin
      work_reg    <= work_next;
      carry_reg   <= carry_next;
      nibble_reg  <= nibble_next;
      zero_reg    <= zero_next;
      tout_n_reg  <= tout_n_next;
      pdown_n_reg <= pdown_n_next;
      wdog_reg    <= wdog_next;
      presc_reg   <= presc_next;
    end
  end

  assign OP_READY_OUT          = ready_reg;
  assign OP_DONE_OUT           = done_reg;
  assign BUS_RDATA_OUT         = rdata_reg;
  assign WORK_REG_OUT          = work_reg;
  assign CARRY_OUT             = carry_reg;
  assign NIBBLE_CARRY_OUT      = nibble_reg;
  assign ZERO_OUT              = zero_reg;
  assign TIMEOUT_FLAG_N_OUT    = tout_n_reg;
  assign POWER_DOWN_FLAG_N_OUT = pdown_n_reg;
  assign HALTED_OUT            = halted_reg;
  assign WDOG_COUNT_OUT        = wdog_reg;
  assign WDOG_PRESCALER_OUT    = presc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  wire [8:0] chk_sum = {1'b0, OP_ARG_IN} + {1'b0, ~WORK_REG_OUT} + {8'h00, CARRY_OUT};
  wire [4:0] chk_low = {1'b0, OP_ARG_IN[3:0]} + {1'b0, ~WORK_REG_OUT[3:0]} + {4'h0, CARRY_OUT};

  property p_sub_value;
    logic [8:0] s;
    (take_sub, s = chk_sum) |=> ({CARRY_OUT, WORK_REG_OUT} == s) && (ZERO_OUT == (s[7:0] == 8'h00));
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("subtract result or flags wrong");

  property p_sub_nibble;
    take_sub |=> NIBBLE_CARRY_OUT == $past(chk_low[4]);
  endproperty
  a_sub_nibble: assert property (p_sub_nibble) else $error("nibble carry wrong");

  property p_sub_one_cycle;
    take_sub |=> OP_DONE_OUT && OP_READY_OUT;
  endproperty
  a_sub_one_cycle: assert property (p_sub_one_cycle) else $error("subtract not done in one cycle");

  property p_sub_borrow;
    take_sub && ({1'b0, OP_ARG_IN} < ({1'b0, WORK_REG_OUT} + {8'h00, !CARRY_OUT})) |=> !CARRY_OUT;
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("carry set despite borrow");

  sequence s_flags_kept;
    $stable({CARRY_OUT, NIBBLE_CARRY_OUT, ZERO_OUT});
  endsequence

  property p_page_read;
    take_pread |=> (!OP_READY_OUT and s_flags_kept) ##1 (WORK_REG_OUT == $past(page_rdata)) && OP_DONE_OUT;
  endproperty
  a_page_read: assert property (p_page_read) else $error("page read did not load working register");

  property p_page_write;
    take_pwrite |=> s_flags_kept and OP_DONE_OUT;
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write disturbed flags");

  property p_halt_clear;
    take_halt |=> (WDOG_COUNT_OUT == 8'h00) && (WDOG_PRESCALER_OUT == 8'h00);
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("watchdog not cleared by halt");

  property p_halt_flags;
    take_halt |=> (TIMEOUT_FLAG_N_OUT && !POWER_DOWN_FLAG_N_OUT) and s_flags_kept;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_halt_stop;
    take_halt |=> HALTED_OUT && !OP_READY_OUT && OP_DONE_OUT ##1 !OP_DONE_OUT;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt mode not entered");

  property p_halt_frozen;
    HALTED_OUT && !wr_wake |=> HALTED_OUT && $stable(WORK_REG_OUT) && $stable(WDOG_PRESCALER_OUT);
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("execution continued in halt mode");

endmodule

// File: tb/tb.sv
// Self-checking bench for the subtract, special-page and halt execution unit
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       op_valid = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [7:0] op_arg = 8'h00;
  logic       op_ready;
  logic       op_done;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr = 1'b0;
  logic       bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic [7:0] work;
  logic       carry;
  logic       nibble;
  logic       zero;
  logic       tout_n;
  logic       pdown_n;
  logic       halted;
  logic [7:0] wdog;
  logic [7:0] presc;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;
  logic [7:0] rd_val;

  always #50 clk_in = ~clk_in;

  sbh_exec sbh_exec_inst (
    .CLK_IN                (clk_in),
    .RST_N_IN              (rst_n_in),
    .OP_VALID_IN           (op_valid),
    .OP_CODE_IN            (op_code),
    .OP_ARG_IN             (op_arg),
    .OP_READY_OUT          (op_ready),
    .OP_DONE_OUT           (op_done),
    .BUS_ADDR_IN           (bus_addr),
    .BUS_WDATA_IN          (bus_wdata),
    .BUS_WR_IN             (bus_wr),
    .BUS_RD_IN             (bus_rd),
    .BUS_RDATA_OUT         (bus_rdata),
    .WORK_REG_OUT          (work),
    .CARRY_OUT             (carry),
    .NIBBLE_CARRY_OUT      (nibble),
    .ZERO_OUT              (zero),
    .TIMEOUT_FLAG_N_OUT    (tout_n),
    .POWER_DOWN_FLAG_N_OUT (pdown_n),
    .HALTED_OUT            (halted),
    .WDOG_COUNT_OUT        (wdog),
    .WDOG_PRESCALER_OUT    (presc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the watchdog wait needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_write(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    bus_wr    <= 1'b1;
    bus_addr  <= addr;
    bus_wdata <= data;
    @(posedge clk_in);
    bus_wr    <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    bus_rd   <= 1'b1;
    bus_addr <= addr;
    @(posedge clk_in);
    bus_rd   <= 1'b0;
    #1 data = bus_rdata;
  endtask

  task automatic do_op(input logic [1:0] code, input logic [7:0] arg);
    @(posedge clk_in);
    op_valid <= 1'b1;
    op_code  <= code;
    op_arg   <= arg;
    @(posedge clk_in);
    op_valid <= 1'b0;
    if (code == sbh_pkg::OP_PAGE_READ) begin
      // Registered page data costs one bubble cycle
      #1 chk("ready bubble", 8'h00, {7'h00, op_ready});
      @(posedge clk_in);
    end
    #1 chk("done pulse", 8'h01, {7'h00, op_done});
  endtask

  // Reference: {carry, nibble carry, zero, result}
  function automatic logic [10:0] sub_ref(input logic [7:0] i, input logic [7:0] w, input logic c);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, i} + {1'b0, ~w} + {8'h00, c};
    n = {1'b0, i[3:0]} + {1'b0, ~w[3:0]} + {4'h0, c};
    return {s[8], n[4], s[7:0] == 8'h00, s[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  t_i [6] = '{8'h05, 8'h05, 8'h06, 8'h06, 8'hFF, 8'h18};
  logic [7:0]  t_w [6] = '{8'h06, 8'h06, 8'h05, 8'h05, 8'h00, 8'h09};
  logic        t_c [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  // Hand-worked results, independent of the reference function
  logic [7:0]  t_r [6] = '{8'hFE, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'h0F};
  logic [3:0]  idx [3] = '{4'h0, 4'h5, 4'hF};
  logic [10:0] exp_s;

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1 chk("work after reset", 8'h00, work);
    chk("flags after reset", 8'h18, {3'h0, tout_n, pdown_n, zero, nibble, carry});
    bus_read(sbh_pkg::OFS_STATUS, rd_val);
    chk("status read", 8'h18, rd_val);
    bus_read(4'h7, rd_val);
    chk("unmapped read", 8'h00, rd_val);
    $display("test reset done");

    for (int k = 0; k < 6; k++) begin
      bus_write(sbh_pkg::OFS_WORK, t_w[k]);
      bus_write(sbh_pkg::OFS_STATUS, {7'h0C, t_c[k]});
      exp_s = sub_ref(t_i[k], t_w[k], t_c[k]);
      do_op(sbh_pkg::OP_SUB_BORROW_IMM, t_i[k]);
      chk("sub result", exp_s[7:0], work);
      chk("sub literal", t_r[k], work);
      chk("sub zero", {7'h00, exp_s[8]}, {7'h00, zero});
      chk("sub nibble", {7'h00, exp_s[9]}, {7'h00, nibble});
      chk("sub carry", {7'h00, exp_s[10]}, {7'h00, carry});
    end
    $display("test subtract done");

    bus_write(sbh_pkg::OFS_STATUS, 8'h1A);
    for (int k = 0; k < 3; k++) begin
      bus_write(sbh_pkg::OFS_WORK, 8'hA0 + {4'h0, idx[k]});
      // Upper index bits set to show they are ignored
      do_op(sbh_pkg::OP_PAGE_WRITE, {4'hF, idx[k]});
      chk("write flags", 8'h1A, {3'h0, tout_n, pdown_n, zero, nibble, carry});
    end
    bus_write(sbh_pkg::OFS_STATUS, 8'h05);
    for (int k = 2; k >= 0; k--) begin
      bus_write(sbh_pkg::OFS_WORK, 8'h3C);
      do_op(sbh_pkg::OP_PAGE_READ, {4'h0, idx[k]});
      chk("page read", 8'hA0 + {4'h0, idx[k]}, work);
      chk("read flags", 8'h05, {3'h0, tout_n, pdown_n, zero, nibble, carry});
    end
    $display("test page done");

    bus_write(sbh_pkg::OFS_WDOG, 8'h77);
    repeat (300) @(posedge clk_in);
    #1 chk("watchdog running", 8'h01, {7'h00, wdog != 8'h00 && presc != 8'h00});
    bus_write(sbh_pkg::OFS_STATUS, 8'h0F);
    do_op(sbh_pkg::OP_HALT, 8'h00);
    chk("halt count", 8'h00, wdog);
    chk("halt prescaler", 8'h00, presc);
    chk("halt flags", 8'h37, {2'h0, halted, tout_n, pdown_n, zero, nibble, carry});
    chk("halt ready", 8'h00, {7'h00, op_ready});
    @(posedge clk_in);
    op_valid <= 1'b1;
    op_code  <= sbh_pkg::OP_SUB_BORROW_IMM;
    op_arg   <= 8'h55;
    repeat (3) @(posedge clk_in);
    op_valid <= 1'b0;
    #1 chk("halted done", 8'h00, {7'h00, op_done});
    chk("halted work", 8'hA0, work);
    chk("halted prescaler", 8'h00, presc);
    bus_read(sbh_pkg::OFS_STATUS, rd_val);
    chk("halt status", 8'h37, rd_val);
    bus_read(sbh_pkg::OFS_WDOG, rd_val);
    chk("halt count read", 8'h00, rd_val);
    bus_read(sbh_pkg::OFS_PRESCALE, rd_val);
    chk("halt prescaler read", 8'h00, rd_val);
    bus_read(sbh_pkg::OFS_WORK, rd_val);
    chk("halt work read", 8'hA0, rd_val);
    bus_write(sbh_pkg::OFS_WAKE, 8'h01);
    @(posedge clk_in);
    #1 chk("wake ready", 8'h01, {7'h00, op_ready});
    chk("wake halted", 8'h00, {7'h00, halted});
    $display("test halt done");

    stop_test();
  end
endmodule
